// ===== design/vcpr_pkg.sv
// Package for the VCONN-powered PD responder: constants, types, notes on behaviour
// Notes on behaviour
// - Full-featured cable carries an identity responder
// - Answer Discover Identity on SOP' with capabilities
// - Ready within 50 ms after VCONN applied; code raises ready_o READY_COUNT+1 cycles after VCONN is sampled
// - Without VCONN stay passive on CC
// - Active cable provides SOP', optionally SOP''
// - Identity states one or two lanes
// - VCONN loss without VBUS means detach
// - Accessory: VCONN arrival attaches, answers PD
// - Accessory must enter alt mode before timeout
// - Function: VCONN arrival without VBUS attaches
// - Function answers SOP' only, ignores others
// - Function reacts to Hard and Cable Reset
// - Drop all messages while charge-through enabled
// - VBUS loss with VCONN keeps attachment
// - Only CC passes to charge-through port
package vcpr_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SUPPLY_TO_READY_MS = 50;
  // Readiness is a longest time, so round down
  localparam int unsigned READY_CYCLES = (CLK_HZ / 1000) * SUPPLY_TO_READY_MS;
  localparam int unsigned ALT_MODE_ENTRY_TIMEOUT_MS = 1000;
  localparam int unsigned ALT_MODE_CYCLES = (CLK_HZ / 1000) * ALT_MODE_ENTRY_TIMEOUT_MS;

  // Packet types as seen by the PHY
  typedef enum logic [2:0] {
    VCPR_SOP, VCPR_SOP_P, VCPR_SOP_PP, VCPR_HARD_RESET, VCPR_CABLE_RESET
  } vcpr_pkt_t;

  typedef enum logic [1:0] {
    VCPR_ROLE_CABLE, VCPR_ROLE_ACCESSORY, VCPR_ROLE_FUNCTION
  } vcpr_role_t;

  localparam logic [4:0] CMD_DISCOVER_IDENTITY = 5'h01;

  typedef struct packed {
    logic valid;
    vcpr_pkt_t pkt;
    logic [4:0] cmd;
  } vcpr_rx_t;

  typedef struct packed {
    logic valid;
    vcpr_pkt_t pkt;
    logic [4:0] cmd;
    logic [31:0] data;
  } vcpr_tx_t;

  typedef struct packed {
    logic [15:0] vendor;
    logic [1:0] current;
    logic [2:0] speed;
    logic two_lanes;
  } vcpr_ident_t;

  localparam logic [15:0] VENDOR_ID_DEFAULT = 16'h1234; // Arbitrary value
endpackage

// ===== design/vcpr_responder.sv
// Message-level responder for VCONN-powered cables, accessories and functions
`timescale 1ns/1ps
module vcpr_responder
  import vcpr_pkg::*;
#(
  parameter int unsigned READY_COUNT = READY_CYCLES,
  parameter int unsigned ALT_COUNT = ALT_MODE_CYCLES,
  parameter logic HAS_SOP_PP = 1'b0,
  parameter logic [15:0] VENDOR_ID = VENDOR_ID_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire vcpr_role_t role_i,
  input wire logic vconn_i,
  input wire logic vbus_i,
  input wire logic ct_enable_i,
  input wire logic alt_mode_entered_i,
  input wire logic [1:0] current_i,
  input wire logic [2:0] speed_i,
  input wire logic two_lanes_i,
  input wire vcpr_rx_t rx_i,
  output vcpr_tx_t tx_o,
  output logic ready_o,
  output logic attached_o,
  output logic cc_drive_en_o,
  output logic reset_seen_o,
  output logic alt_timeout_o
);
  typedef enum logic [1:0] {VCPR_OFF, VCPR_WAIT, VCPR_READY} vcpr_state_t;

  vcpr_state_t state;
  logic [31:0] ready_cnt;
  logic [31:0] alt_cnt;
  logic vconn_q;

  // Which packet types this role answers; resets are handled apart
  function automatic logic accepts(input vcpr_role_t role, input vcpr_pkt_t pkt,
                                   input logic pp);
    case (role)
      VCPR_ROLE_CABLE: begin
        accepts = (pkt == VCPR_SOP_P) || (pp && pkt == VCPR_SOP_PP);
      end
      VCPR_ROLE_FUNCTION: begin
        accepts = (pkt == VCPR_SOP_P);
      end
      VCPR_ROLE_ACCESSORY: begin
        accepts = (pkt == VCPR_SOP);
      end
      default: begin
        accepts = 1'b0;
      end
    endcase
  endfunction

  function automatic logic is_reset_pkt(input vcpr_pkt_t pkt);
    is_reset_pkt = (pkt == VCPR_HARD_RESET) || (pkt == VCPR_CABLE_RESET);
  endfunction

  // Reply word; reserved bits kept zero so fields can grow later
  function automatic logic [31:0] ident_word(input vcpr_ident_t id);
    ident_word = {id.vendor, 10'h000, id.current, id.speed, id.two_lanes};
  endfunction

  logic is_reset;
  logic take;
  logic vconn_rise;
  logic ready_done;
  logic alt_armed;
  logic alt_expired;
  vcpr_ident_t ident;

  // Resets flagged in any live state, but not while CC is bridged
  always_comb begin
    is_reset = rx_i.valid && is_reset_pkt(rx_i.pkt);
  end

  // Charge-through path open: every message dropped
  always_comb begin
    take = rx_i.valid && !ct_enable_i && state == VCPR_READY &&
      accepts(role_i, rx_i.pkt, HAS_SOP_PP);
  end

  // Compare with last sample: an edge, not a level, attaches
  always_comb begin
    vconn_rise = vconn_i && !vconn_q;
  end

  // Terminal count of the readiness timer
  always_comb begin
    ready_done = ready_cnt >= READY_COUNT - 32'd1;
  end

  always_comb begin
    ident.vendor = VENDOR_ID;
    ident.current = current_i;
    ident.speed = speed_i;
    ident.two_lanes = two_lanes_i;
  end

  // Previous VCONN sample; idle level is low, so no false edge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vconn_q <= 1'b0;
    end else begin
      vconn_q <= vconn_i;
    end
  end

  // Readiness counted from VCONN detection; logic idle before it
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= VCPR_OFF;
      ready_cnt <= '0;
    end else if (!vconn_i) begin
      state <= VCPR_OFF;
      ready_cnt <= '0;
    end else begin
      case (state)
        VCPR_OFF: begin
          state <= VCPR_WAIT;
          ready_cnt <= '0;
        end
        VCPR_WAIT: begin
          // Ready only after READY_COUNT cycles of WAIT, by default the whole 50 ms limit
          if (ready_done) begin
            state <= VCPR_READY;
          end else begin
            ready_cnt <= ready_cnt + 32'd1;
          end
        end
        VCPR_READY: begin
          state <= VCPR_READY;
        end
        default: begin
          state <= VCPR_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= vconn_i && state == VCPR_READY;
    end
  end

  // CC transmitter only enabled with VCONN and no bridge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cc_drive_en_o <= 1'b0;
    end else begin
      cc_drive_en_o <= vconn_i && state == VCPR_READY && !ct_enable_i;
    end
  end

  // Attach on VCONN arrival except as cable; VBUS loss alone never detaches
  // VBUS is not looked at: VCONN is the sole detach signal
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      attached_o <= 1'b0;
    end else if (role_i != VCPR_ROLE_CABLE) begin
      if (vconn_rise) begin
        attached_o <= 1'b1;
      end else if (!vconn_i) begin
        attached_o <= 1'b0;
      end
    end else begin
      attached_o <= 1'b0;
    end
  end

  // Accessory watchdog on VCONN alone; cleared once alt mode is in
  always_comb begin
    alt_armed = role_i == VCPR_ROLE_ACCESSORY && vconn_i && !vbus_i &&
      !alt_mode_entered_i;
  end
  always_comb begin
    alt_expired = alt_cnt >= ALT_COUNT - 32'd1;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alt_cnt <= '0;
    end else if (!alt_armed) begin
      alt_cnt <= '0;
    end else if (!alt_expired) begin
      alt_cnt <= alt_cnt + 32'd1;
    end
  end

  // Flag only; removing VCONN is the partner's job
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alt_timeout_o <= 1'b0;
    end else if (!alt_armed) begin
      alt_timeout_o <= 1'b0;
    end else if (alt_expired) begin
      alt_timeout_o <= 1'b1;
    end
  end

  // Readiness kept across resets; the flag is the only reaction
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reset_seen_o <= 1'b0;
    end else begin
      reset_seen_o <= is_reset && state != VCPR_OFF && !ct_enable_i;
    end
  end

  // Identity reply; anything else is silently dropped
  // Payload refreshed every cycle so it is settled with the valid pulse
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_o <= '0;
    end else begin
      tx_o.valid <= take && rx_i.cmd == CMD_DISCOVER_IDENTITY;
      tx_o.pkt <= rx_i.pkt;
      tx_o.cmd <= CMD_DISCOVER_IDENTITY;
      tx_o.data <= ident_word(ident);
    end
  end
endmodule

// ===== verif/vcpr_host_model.sv
// Host port controller model issuing PD messages
`timescale 1ns/1ps
module vcpr_host_model
  import vcpr_pkg::*;
(
  input wire logic clock_i,
  output vcpr_rx_t rx_o
);
  initial rx_o = '0;
  // Sourcing port queries SOP' before a contract
  // Only queries and resets: no swaps, no capability ads, no alt modes
  task automatic send(input vcpr_pkt_t p, input logic [4:0] c);
    @(negedge clock_i);
    rx_o = {1'b1, p, c};
    @(negedge clock_i);
    rx_o = {1'b0, ~p, ~c};
  endtask
endmodule

// ===== verif/vcpr_responder_assertions.sv
// Assertion checker for the VCONN-powered responder
`timescale 1ns/1ps
module vcpr_checker
  import vcpr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire vcpr_role_t role_i,
  input wire logic vconn_i,
  input wire logic ct_enable_i,
  input wire vcpr_rx_t rx_i,
  input wire vcpr_tx_t tx_o,
  input wire logic ready_o,
  input wire logic attached_o,
  input wire logic reset_seen_o,
  input wire logic cc_drive_en_o,
  input wire logic alt_timeout_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic ok;
  assign ok = rx_i.valid && ready_o && vconn_i && !ct_enable_i;
  property p_ans; ok && role_i != VCPR_ROLE_ACCESSORY && rx_i.pkt == VCPR_SOP_P &&
    rx_i.cmd == CMD_DISCOVER_IDENTITY |=> tx_o.valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_sop; rx_i.valid && role_i != VCPR_ROLE_ACCESSORY && rx_i.pkt == VCPR_SOP
    |=> !tx_o.valid; endproperty
  a_sop: assert property (p_sop) else $error("SOP answered");
  property p_ct; rx_i.valid && ct_enable_i |=> !tx_o.valid && !reset_seen_o; endproperty
  a_ct: assert property (p_ct) else $error("message not dropped");
  property p_rdy; $rose(vconn_i) |-> ##[1:20] ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_off; !vconn_i |=> !ready_o && !attached_o; endproperty
  a_off: assert property (p_off) else $error("active without supply");
  property p_att; $rose(vconn_i) && role_i != VCPR_ROLE_CABLE |=> attached_o; endproperty
  a_att: assert property (p_att) else $error("no attach");
  property p_keep; attached_o && vconn_i |=> attached_o; endproperty
  a_keep: assert property (p_keep) else $error("lost attach");
  property p_rst; ok && rx_i.pkt inside {VCPR_HARD_RESET, VCPR_CABLE_RESET} |=> reset_seen_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not seen");
  property p_cc; !vconn_i || ct_enable_i |=> !cc_drive_en_o; endproperty
  a_cc: assert property (p_cc) else $error("CC driven while passive");
  property p_alt; role_i != VCPR_ROLE_ACCESSORY |=> !alt_timeout_o; endproperty
  a_alt: assert property (p_alt) else $error("timeout outside accessory");
  c_ans: cover property (ok ##1 tx_o.valid);
  c_rdy: cover property ($rose(ready_o));
  c_rst: cover property (reset_seen_o);
  c_alt: cover property ($rose(alt_timeout_o));
endmodule

bind vcpr_responder vcpr_checker i_chk (.*);

// ===== verif/vcpr_responder_bench.sv
// Self-checking bench for the VCONN-powered responder
`timescale 1ns/1ps
module vcpr_responder_bench;
  import vcpr_pkg::*;
  logic clock_i = 0, rstn_i = 0, vconn = 0, vbus = 0, ct_en = 0, tl = 0, alt_in = 0;
  vcpr_role_t role = VCPR_ROLE_FUNCTION;
  logic [1:0] cur = 0;
  logic [2:0] spd = 0;
  logic [31:0] seed = 32'h0000_c2a4;
  int num_errors = 0, checks_done = 0;
  logic [31:0] exp_q[$];
  logic exp_rst_q[$];
  vcpr_rx_t rx;
  vcpr_tx_t tx;
  logic ready, att, cc_en, rst_seen, alt_to;
  vcpr_host_model i_host (.clock_i(clock_i), .rx_o(rx));
  vcpr_responder #(.READY_COUNT(10), .ALT_COUNT(20)) i_dut (.clock_i(clock_i),
    .rstn_i(rstn_i), .role_i(role), .vconn_i(vconn), .vbus_i(vbus),
    .ct_enable_i(ct_en), .alt_mode_entered_i(alt_in), .current_i(cur), .speed_i(spd),
    .two_lanes_i(tl), .rx_i(rx), .tx_o(tx), .ready_o(ready), .attached_o(att),
    .cc_drive_en_o(cc_en), .reset_seen_o(rst_seen), .alt_timeout_o(alt_to));
  task automatic cmp_tx(input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (e !== s) begin
      num_errors++;
      $display("MISMATCH tx_o.data expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic s);
    checks_done++;
    if (e !== s) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic msg(input vcpr_pkt_t p, input logic [4:0] c, input logic ans);
    if (ans) exp_q.push_back({VENDOR_ID_DEFAULT, 10'h000, cur, spd, tl});
    if ((p == VCPR_HARD_RESET || p == VCPR_CABLE_RESET) && !ct_en) exp_rst_q.push_back(1'b1);
    i_host.send(p, c);
  endtask
  task automatic rand_ident();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    {cur, spd, tl} = seed[5:0];
  endtask
  task automatic power_up(input vcpr_role_t r);
    vconn = 0;
    repeat (2) @(negedge clock_i);
    role = r;
    @(negedge clock_i);
    vconn = 1;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge clock_i);
    cmp_bit("ready_o", 1'b1, ready);
  endtask
  initial forever #12.5 clock_i = ~clock_i;
  // Every response must match the oldest expected one
  always @(negedge clock_i) begin
    if (tx.valid === 1'b1 && exp_q.size() == 0) cmp_bit("tx_o.valid", 1'b0, 1'b1);
    else if (tx.valid === 1'b1) cmp_tx(exp_q.pop_front(), tx.data);
    if (rst_seen === 1'b1 && exp_rst_q.size() == 0) cmp_bit("reset_seen_o", 1'b0, 1'b1);
    else if (rst_seen === 1'b1) cmp_bit("reset_seen_o", exp_rst_q.pop_front(), rst_seen);
  end
  initial begin
    repeat (8) @(negedge clock_i);
    rstn_i = 1;
    rand_ident();
    power_up(VCPR_ROLE_FUNCTION);
    cmp_bit("attached_o", 1'b1, att);
    cmp_bit("cc_drive_en_o", 1'b1, cc_en);
    for (int k = 0; k < 5; k++) msg(vcpr_pkt_t'(k), CMD_DISCOVER_IDENTITY, k == 1);
    msg(VCPR_SOP_P, 5'h02, 1'b0);
    ct_en = 1;
    @(negedge clock_i);
    cmp_bit("cc_drive_en_o", 1'b0, cc_en);
    msg(VCPR_SOP_P, CMD_DISCOVER_IDENTITY, 1'b0);
    msg(VCPR_HARD_RESET, CMD_DISCOVER_IDENTITY, 1'b0);
    ct_en = 0;
    $display("identity test done");
    vbus = 1;
    rand_ident();
    msg(VCPR_SOP_P, CMD_DISCOVER_IDENTITY, 1'b1);
    vbus = 0;
    repeat (3) @(negedge clock_i);
    cmp_bit("attached_o", 1'b1, att);
    vconn = 0;
    repeat (2) @(negedge clock_i);
    cmp_bit("attached_o", 1'b0, att);
    cmp_bit("ready_o", 1'b0, ready);
    cmp_bit("cc_drive_en_o", 1'b0, cc_en);
    $display("attach test done");
    rand_ident();
    power_up(VCPR_ROLE_CABLE);
    cmp_bit("attached_o", 1'b0, att);
    msg(VCPR_SOP_P, CMD_DISCOVER_IDENTITY, 1'b1);
    msg(VCPR_SOP_PP, CMD_DISCOVER_IDENTITY, 1'b0);
    msg(VCPR_SOP, CMD_DISCOVER_IDENTITY, 1'b0);
    $display("cable test done");
    power_up(VCPR_ROLE_ACCESSORY);
    cmp_bit("alt_timeout_o", 1'b0, alt_to);
    msg(VCPR_SOP, CMD_DISCOVER_IDENTITY, 1'b1);
    msg(VCPR_SOP_P, CMD_DISCOVER_IDENTITY, 1'b0);
    for (int n = 0; n < 20 && alt_to !== 1'b1; n++) @(negedge clock_i);
    cmp_bit("alt_timeout_o", 1'b1, alt_to);
    alt_in = 1;
    @(negedge clock_i);
    cmp_bit("alt_timeout_o", 1'b0, alt_to);
    cmp_bit("all answered", 1'b1, exp_q.size() == 0);
    cmp_bit("all resets seen", 1'b1, exp_rst_q.size() == 0);
    $display("accessory test done");
    stop_test();
  end
endmodule
